// ==== core/coalesce_pkg.sv ====
// package for the memory-to-stream interrupt coalescing block
// assumes a single 50 MHz clock domain and the control register written through a plain port
package coalesce_pkg;

	// ----------------------------------------------------------------
	// control register layout
	// ----------------------------------------------------------------
	localparam int         CTRL_W            = 32;
	localparam int         CNT_LSB           = 16;
	localparam int         TMO_LSB           = 24;
	localparam int         CIE_BIT           = 12;
	localparam int         TIE_BIT           = 13;
	localparam logic [7:0] CNT_RESET         = 8'h01;
	localparam logic [7:0] TMO_RESET         = 8'h00;
	localparam logic [7:0] CNT_ZERO          = 8'h00;

	// ----------------------------------------------------------------
	// timebase
	// ----------------------------------------------------------------
	localparam int         CLK_PERIOD_NS     = 20;
	localparam int         TICK_TIME_NS      = 1000;
	localparam int         TICK_CYCLES       = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// control fields that steer the logic
	typedef struct packed {
		logic [7:0] idle_timeout_setting;
		logic [7:0] coalesce_count_setting;
		logic       timeout_irq_enable;
		logic       complete_irq_enable;
	} ctrl_fields_t;

	// delay timer states, gray along idle -> run
	typedef enum logic [1:0] {
		TMR_IDLE = 2'b00,
		TMR_RUN  = 2'b01
	} tmr_state_t;

endpackage

// ==== core/coalesce_tick.sv ====
// free-running timebase pulse for the delay timer
// assumes one clock, asynchronous active-low reset
module coalesce_tick
	import coalesce_pkg::*;
#(
	parameter int DIV = TICK_CYCLES
) (
	input  wire logic ref_clk_i,
	input  wire logic arst_n_i,
	output logic      tick_o
);

	logic [15:0] div_q;
	logic [15:0] div_d;
	logic        tick_q;
	logic        tick_d;

	// count down, pulse once per period
	always_comb begin
		tick_d = 1'b0;
		div_d  = div_q - 16'h0001;
		if (div_q == 16'h0000) begin
			div_d  = 16'(DIV - 1);
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div_q  <= 16'h0000;
			tick_q <= 1'b0;
		end else begin
			div_q  <= div_d;
			tick_q <= tick_d;
		end
	end

	assign tick_o = tick_q;

endmodule

// ==== core/coalesce_irq.sv ====
// interrupt coalescing for the memory-to-stream channel
// assumes control writes arrive as a word with a one-cycle strobe; events are one-cycle pulses
// ----------------------------------------------------------------
// top module
// ----------------------------------------------------------------
// Notes on behaviour
// - the count setting lives in control bits 23..16, is read/write and resets to one.
// - each marked completion decrements a counter loaded from the count setting and fires at zero.
// - one is the least count; a write of zero to the count field keeps the old value.
// - with descriptor mode off both count and timeout settings are ignored.
// - the interrupt rises when the delay timer reaches the timeout setting.
// - the delay timer clears on a new packet or on a timeout.
// - a timeout setting of zero never fires the delay interrupt.
// - the count interrupt reaches the output only with bit 12 set and a marked descriptor.
// - the delay interrupt reaches the output only with bit 13 set.
module coalesce_irq
	import coalesce_pkg::*;
#(
	parameter bit DESCRIPTOR_MODE_PARAM = 1'b1,
	parameter int TICK_DIV              = TICK_CYCLES
) (
	input  wire logic              ref_clk_i,
	input  wire logic              arst_n_i,
	input  wire logic              ctrl_wr_i,
	input  wire logic [CTRL_W-1:0] ctrl_wdata_i,
	output logic      [CTRL_W-1:0] read_channel_control_o,
	input  wire logic              completion_event_i,
	input  wire logic              completion_marked_i,
	input  wire logic              packet_start_i,
	input  wire logic              packet_end_i,
	output logic                   irq_o
);

	ctrl_fields_t ctrl_q;
	ctrl_fields_t ctrl_d;
	logic [7:0]   cnt_q;
	logic [7:0]   cnt_d;
	logic [7:0]   tmr_q;
	logic [7:0]   tmr_d;
	tmr_state_t   st_q;
	tmr_state_t   st_d;
	logic         irq_q;
	logic         irq_d;
	logic [31:0]  rd_q;
	logic [31:0]  rd_d;
	logic         tick;
	logic         cnt_fire;
	logic         tmo_fire;
	logic [7:0]   wr_cnt;

	// ----------------------------------------------------------------
	// timebase
	// ----------------------------------------------------------------
	coalesce_tick #(
		.DIV (TICK_DIV)
	) u_tick (
		.ref_clk_i (ref_clk_i),
		.arst_n_i  (arst_n_i),
		.tick_o    (tick)
	);

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	assign wr_cnt = ctrl_wdata_i[CNT_LSB +: 8];

	// field writes; zero count keeps the stored value
	always_comb begin
		ctrl_d = ctrl_q;
		if (ctrl_wr_i) begin
			ctrl_d.complete_irq_enable  = ctrl_wdata_i[CIE_BIT];
			ctrl_d.timeout_irq_enable   = ctrl_wdata_i[TIE_BIT];
			ctrl_d.idle_timeout_setting = ctrl_wdata_i[TMO_LSB +: 8];
			if (wr_cnt != CNT_ZERO) begin
				ctrl_d.coalesce_count_setting = wr_cnt;
			end
		end
	end

	// read image of the control word
	always_comb begin
		rd_d                 = '0;
		rd_d[CNT_LSB +: 8]   = ctrl_d.coalesce_count_setting;
		rd_d[TMO_LSB +: 8]   = ctrl_d.idle_timeout_setting;
		rd_d[CIE_BIT]        = ctrl_d.complete_irq_enable;
		rd_d[TIE_BIT]        = ctrl_d.timeout_irq_enable;
	end

	// ----------------------------------------------------------------
	// completion counter
	// ----------------------------------------------------------------
	// counts down marked completions, reloads on firing
	always_comb begin
		cnt_d    = cnt_q;
		cnt_fire = 1'b0;
		if (DESCRIPTOR_MODE_PARAM && completion_event_i && completion_marked_i) begin
			if (cnt_q <= 8'h01) begin
				cnt_fire = 1'b1;
				cnt_d    = ctrl_q.coalesce_count_setting;
			end else begin
				cnt_d = cnt_q - 8'h01;
			end
		end
		if (ctrl_wr_i && wr_cnt != CNT_ZERO && !cnt_fire) begin
			cnt_d = wr_cnt; // new setting restarts the count
		end
	end

	// ----------------------------------------------------------------
	// delay timer
	// ----------------------------------------------------------------
	// idle until packet end, then count ticks up to the setting
	always_comb begin
		st_d     = st_q;
		tmr_d    = tmr_q;
		tmo_fire = 1'b0;
		case (st_q)
			TMR_IDLE: begin
				if (packet_end_i && DESCRIPTOR_MODE_PARAM && ctrl_q.idle_timeout_setting != 8'h00) begin
					st_d  = TMR_RUN;
					tmr_d = 8'h00;
				end
			end
			TMR_RUN: begin
				if (packet_start_i || ctrl_q.idle_timeout_setting == 8'h00) begin
					st_d  = TMR_IDLE;
					tmr_d = 8'h00;
				end else if (tick) begin
					if (tmr_q + 8'h01 >= ctrl_q.idle_timeout_setting) begin
						tmo_fire = 1'b1;
						st_d     = TMR_IDLE;
						tmr_d    = 8'h00;
					end else begin
						tmr_d = tmr_q + 8'h01;
					end
				end
			end
			default: begin
				st_d  = TMR_IDLE;
				tmr_d = 8'h00;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// interrupt output
	// ----------------------------------------------------------------
	// one-cycle pulse for each cycle with a gated event; count and delay events in one cycle give one pulse
	always_comb begin
		irq_d = (cnt_fire && ctrl_q.complete_irq_enable)
			|| (tmo_fire && ctrl_q.timeout_irq_enable);
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_q <= '{idle_timeout_setting: TMO_RESET, coalesce_count_setting: CNT_RESET,
				timeout_irq_enable: 1'b0, complete_irq_enable: 1'b0};
			cnt_q  <= CNT_RESET;
			tmr_q  <= 8'h00;
			st_q   <= TMR_IDLE;
			irq_q  <= 1'b0;
			rd_q   <= {TMO_RESET, CNT_RESET, 16'h0000};
		end else begin
			ctrl_q <= ctrl_d;
			cnt_q  <= cnt_d;
			tmr_q  <= tmr_d;
			st_q   <= st_d;
			irq_q  <= irq_d;
			rd_q   <= rd_d;
		end
	end

	assign irq_o                  = irq_q;
	assign read_channel_control_o = rd_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_wr_zero;
		ctrl_wr_i && ctrl_wdata_i[CNT_LSB +: 8] == 8'h00;
	endsequence

	chk_zero_write_kept: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		s_wr_zero |=> read_channel_control_o[23:16] == $past(read_channel_control_o[23:16]))
		else $error("zero count write changed the setting");

	chk_count_never_zero: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		read_channel_control_o[23:16] != 8'h00)
		else $error("count setting read as zero");

	chk_count_fire_irq: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		cnt_fire && ctrl_q.complete_irq_enable |=> irq_o)
		else $error("count reached zero without interrupt");

	chk_count_reload: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		cnt_fire && !ctrl_wr_i |=> cnt_q == $past(ctrl_q.coalesce_count_setting))
		else $error("counter not reloaded");

	// only a descriptor-mode channel counts; simple mode leaves the counter alone
	chk_decrement: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		DESCRIPTOR_MODE_PARAM && completion_event_i && completion_marked_i && !cnt_fire && !ctrl_wr_i
		|=> cnt_q == $past(cnt_q) - 8'h01)
		else $error("counter did not decrement");

	chk_irq_cause: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		irq_o |-> $past(cnt_fire && ctrl_q.complete_irq_enable) || $past(tmo_fire && ctrl_q.timeout_irq_enable))
		else $error("interrupt without gated cause");

	// simple mode never arms the timer, so the start check holds in descriptor mode only
	chk_tmr_start: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		DESCRIPTOR_MODE_PARAM && st_q == TMR_IDLE && packet_end_i && ctrl_q.idle_timeout_setting != 8'h00
		|=> st_q == TMR_RUN && tmr_q == 8'h00)
		else $error("delay timer did not start");

	chk_tmr_clear: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		st_q == TMR_RUN && packet_start_i |=> st_q == TMR_IDLE && !$past(tmo_fire))
		else $error("new packet did not clear timer");

	chk_zero_timeout: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		ctrl_q.idle_timeout_setting == 8'h00 |-> !tmo_fire)
		else $error("delay fired with zero timeout");

	chk_tmo_reach: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		tmo_fire |-> tick && tmr_q + 8'h01 == ctrl_q.idle_timeout_setting)
		else $error("delay fired at wrong count");

endmodule

// ==== tb/coalesce_host.sv ====
// host model: services the channel interrupt line and counts its pulses
// assumes the interrupt is a one-cycle high pulse synchronous to ref_clk_i
module coalesce_host (
	input  wire logic       ref_clk_i,
	input  wire logic       arst_n_i,
	input  wire logic       irq_i,
	output logic      [7:0] irq_count_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// interrupt service
	// ----------------------------------------------------------------
	// each serviced pulse bumps the count
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_count_o <= 8'h00;
		end else if (irq_i) begin
			irq_count_o <= irq_count_o + 8'h01;
		end
	end
endmodule

// ==== tb/test_memory_to_stream_interrupt_coalescing.sv ====
// testbench for the interrupt coalescing block, with a host model on the interrupt line
// assumes a 50 MHz clock, a shortened timebase of two cycles and a second copy with descriptor mode off
module test_memory_to_stream_interrupt_coalescing;
	import coalesce_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic              clk;
	logic              arst_n;
	logic              ctrl_wr;
	logic [CTRL_W-1:0] wdata;
	logic [CTRL_W-1:0] image;
	logic [2:0]        strobe;
	logic              marked;
	logic              irq;
	logic              irq_off;
	logic [7:0]        cnt;
	logic [7:0]        cnt_off;
	int                miscompares;
	int                total_checks;
	// ----------------------------------------------------------------
	// design and host models
	// ----------------------------------------------------------------
	coalesce_irq #(.DESCRIPTOR_MODE_PARAM(1'b1), .TICK_DIV(2)) dut_u (.ref_clk_i(clk), .arst_n_i(arst_n),
		.ctrl_wr_i(ctrl_wr), .ctrl_wdata_i(wdata), .read_channel_control_o(image), .completion_event_i(strobe[0]),
		.completion_marked_i(marked), .packet_start_i(strobe[1]), .packet_end_i(strobe[2]), .irq_o(irq));
	coalesce_irq #(.DESCRIPTOR_MODE_PARAM(1'b0), .TICK_DIV(2)) dut_off_u (.ref_clk_i(clk), .arst_n_i(arst_n),
		.ctrl_wr_i(ctrl_wr), .ctrl_wdata_i(wdata), .read_channel_control_o(), .completion_event_i(strobe[0]),
		.completion_marked_i(marked), .packet_start_i(strobe[1]), .packet_end_i(strobe[2]), .irq_o(irq_off));
	coalesce_host host_u (.ref_clk_i(clk), .arst_n_i(arst_n), .irq_i(irq), .irq_count_o(cnt));
	coalesce_host host_off_u (.ref_clk_i(clk), .arst_n_i(arst_n), .irq_i(irq_off), .irq_count_o(cnt_off));
	// clock at 20 ns
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// one-cycle control write, image settles one cycle later
	task automatic wr(input logic [31:0] d);
		@(posedge clk);
		ctrl_wr <= 1'b1;
		wdata <= d;
		@(posedge clk);
		ctrl_wr <= 1'b0;
		#1;
	endtask
	// strobe bits: 0 completion, 1 packet start, 2 packet end
	task automatic pulse(input logic [2:0] s, input logic m);
		@(posedge clk);
		strobe <= s;
		marked <= m;
		@(posedge clk);
		strobe <= 3'h0;
	endtask
	task automatic events(input int n, input logic m);
		repeat (n) pulse(3'h1, m);
		tick(3);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic reg_scn;
		compare("reset image", 32'h0001_0000, image);
		wr(32'h0503_3000);
		compare("written image", 32'h0503_3000, image);
		wr(32'h0700_FFFF);
		compare("zero count write", 32'h0703_3000, image);
	endtask
	task automatic count_scn;
		logic [7:0] c0;
		wr(32'h0003_1000);
		c0 = cnt;
		events(2, 1'b1);
		compare("irq before threshold", c0, cnt);
		events(1, 1'b1);
		compare("irq at threshold", c0 + 8'h01, cnt);
		events(3, 1'b0);
		compare("unmarked events", c0 + 8'h01, cnt);
		events(3, 1'b1);
		compare("irq after reload", c0 + 8'h02, cnt);
		wr(32'h0002_0000);
		events(2, 1'b1);
		compare("count irq disabled", c0 + 8'h02, cnt);
	endtask
	task automatic delay_scn;
		logic [7:0] c0;
		wr(32'h0301_2000);
		c0 = cnt;
		pulse(3'h4, 1'b0);
		tick(5); // three ticks of two cycles: host sees the pulse six or seven cycles after packet end
		compare("delay irq early", c0, cnt);
		tick(7);
		compare("delay irq expiry", c0 + 8'h01, cnt);
		pulse(3'h4, 1'b0);
		tick(2);
		pulse(3'h2, 1'b0);
		tick(14);
		compare("timer cleared by packet", c0 + 8'h01, cnt);
		wr(32'h0001_2000);
		pulse(3'h4, 1'b0);
		tick(14);
		compare("zero timeout", c0 + 8'h01, cnt);
		wr(32'h0301_0000);
		pulse(3'h4, 1'b0);
		tick(14);
		compare("delay irq disabled", c0 + 8'h01, cnt);
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		arst_n = 1'b0;
		ctrl_wr = 1'b0;
		wdata = '0;
		strobe = 3'h0;
		marked = 1'b0;
		miscompares = 0;
		total_checks = 0;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		tick(1);
		reg_scn();
		count_scn();
		delay_scn();
		compare("mode off irq count", 32'h0, {24'h0, cnt_off});
		test_done();
	end
endmodule
